// file: bit_manip_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bit_manip_asserts (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic busy,
	input wire logic done
);
	// ---
	// Helpers
	// ---
	logic [3:0] cnt_r;
	logic [7:0] op_r;
	logic take, legal, short;
	// A counter keeps the length check free of long repetitions.
	always_ff @(posedge clk_sys) begin
		if (srst || !busy) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
	// Opcode of the instruction last taken while idle.
	always_ff @(posedge clk_sys) begin
		if (take && !busy) begin
			op_r <= dat_i[7:0];
		end
	end
	// Instruction writes that reach the unit.
	assign take = cyc_i && stb_i && !ack_o && we_i && sel_i[0]
		&& adr_i[11:2] == 10'h100;
	assign legal = dat_i[7:0] inside {8'h67, 8'h07, 8'h17, 8'h57,
		8'h77, 8'h52};
	assign short = op_r inside {8'h57, 8'h77, 8'h52};
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	// ---
	// Checks
	// ---
	a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack missing");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack unasked");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	a_exec_start: assert property (take && !busy && legal |=> busy)
		else $error("no start");
	a_idle_hold: assert property (!busy && !take |=> !busy)
		else $error("busy unasked");
	a_exec_length: assert property ($fell(busy) && !$past(srst) |->
		cnt_r == (short ? 4'h4 : 4'h6))
		else $error("bad length");
	a_done_after: assert property (done |-> !busy && $past(busy))
		else $error("done misplaced");
	a_done_pulse: assert property (done |=> !done)
		else $error("done too long");
	cover property (done && short);
	cover property (take && !legal);
	cover property (ack_o && !we_i);
endmodule : bit_manip_asserts
bind bit_manipulation_unit bit_manip_asserts i_chk (.clk_sys(clk_sys),
	.srst(srst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.busy(busy), .done(done));
`default_nettype wire

// file: bit_manip_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants for the bit manipulation unit: single-bit operations and byte AND.
// ---------------------------------------------------------------------------
package bit_manip_pkg;

	// Register indexes; the bus byte address is four times the index.
	localparam logic [8:0] IDX_FLAGS = 9'h0_0D5;
	localparam logic [8:0] IDX_INSTR = 9'h0_100;
	localparam logic [8:0] IDX_STATUS = 9'h0_101;
	localparam logic [8:0] IDX_LAST_REG = 9'h0_0FF;

	// Working registers sit in a window of the register space.
	localparam logic [7:0] WORK_BASE = 8'hC0;

	// Opcodes.
	localparam logic [7:0] OPC_BAND = 8'h67;
	localparam logic [7:0] OPC_TOGGLE = 8'h57;
	localparam logic [7:0] OPC_BITRS = 8'h77;
	localparam logic [7:0] OPC_BIT_OR = 8'h07;
	localparam logic [7:0] OPC_BIT_CMP = 8'h17;
	localparam logic [7:0] OPC_AND = 8'h52;

	// Execution lengths in CPU cycles.
	localparam logic [3:0] CYC_3BYTE = 4'h6;
	localparam logic [3:0] CYC_2BYTE = 4'h4;

	// Flag bit positions inside the condition flags register.
	localparam int FLAG_C = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_S = 5;
	localparam int FLAG_V = 4;
	localparam int FLAG_D = 3;
	localparam int FLAG_H = 2;
	localparam logic [7:0] FLAGS_RESET = 8'h00;

	// Status register bit positions.
	localparam int STAT_BUSY = 0;
	localparam int STAT_ILLEGAL = 1;

	// Operation decoded from the opcode.
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_BAND = 3'b001,
		OP_BIT_OR = 3'b010,
		OP_BIT_CMP = 3'b011,
		OP_TOGGLE = 3'b100,
		OP_BITRS = 3'b101,
		OP_AND = 3'b110
	} op_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_EXEC = 1'b1
	} state_t;

endpackage : bit_manip_pkg

// file: bit_manipulation_unit.sv
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Bit AND merges selected bit with other operand's bit 0, both ways.
// - Except in byte AND, only the targeted destination bit changes; the source is never written.
// - Bit AND, OR, complement: Z from result, S cleared, C D H kept.
// - Bit AND is opcode 67, three bytes, six cycles; selector picks form.
// - Operand byte splits into register nibble, bit index, and selector bit.
// - Bit compare sets Z when source bit equals destination bit 0.
// - Flags live in the condition flags register at index 0D5h.
// - Bit complement inverts one bit; opcode 57, two bytes, four cycles.
// - Bit clear forces the bit to zero, opcode 77 selector 0, no flags.
// - Bit set forces the bit to one, opcode 77 selector 1, no flags.
// - Bit OR merges selected bit with other operand's bit 0, both ways.
// - Byte AND stores the bitwise AND of both operands in the destination.
module bit_manipulation_unit (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic busy,
	output logic done
);

	// -----------------------------------------------------------------------
	// Storage and state.
	// -----------------------------------------------------------------------
	logic [7:0] regs [0:255];
	logic [7:0] flagsR;
	bit_manip_pkg::state_t stateR;
	bit_manip_pkg::op_t opR;
	logic [3:0] cntR;
	logic [3:0] nibR;
	logic [2:0] single_bit_clear_op;
	logic selR;
	logic [7:0] thirdR;
	logic illegalR;
	logic ackR;
	logic [31:0] datR;
	logic doneR;

	// -----------------------------------------------------------------------
	// Bus decode.
	// -----------------------------------------------------------------------
	logic req;
	logic wrReq;
	logic [8:0] idx;
	logic instrWr;
	logic [7:0] wOpc;
	bit_manip_pkg::op_t wOp;
	logic [3:0] wCycles;

	// A request is taken in the cycle it appears; ack follows one edge later.
	assign req = cyc_i & stb_i & ~ackR;
	assign idx = adr_i[10:2];
	assign wrReq = req & we_i & sel_i[0] & ~adr_i[11];
	assign instrWr = wrReq & (idx == bit_manip_pkg::IDX_INSTR) &
		(stateR == bit_manip_pkg::ST_IDLE);
	assign wOpc = dat_i[7:0];

	// Opcode decode fixes the operation and its length.
	always_comb begin
		wOp = bit_manip_pkg::OP_NONE;
		wCycles = bit_manip_pkg::CYC_2BYTE;
		case (wOpc)
			bit_manip_pkg::OPC_BAND: begin
				wOp = bit_manip_pkg::OP_BAND;
				wCycles = bit_manip_pkg::CYC_3BYTE;
			end
			bit_manip_pkg::OPC_BIT_OR: begin
				wOp = bit_manip_pkg::OP_BIT_OR;
				wCycles = bit_manip_pkg::CYC_3BYTE;
			end
			bit_manip_pkg::OPC_BIT_CMP: begin
				wOp = bit_manip_pkg::OP_BIT_CMP;
				wCycles = bit_manip_pkg::CYC_3BYTE;
			end
			bit_manip_pkg::OPC_TOGGLE: begin
				wOp = bit_manip_pkg::OP_TOGGLE;
				wCycles = bit_manip_pkg::CYC_2BYTE;
			end
			bit_manip_pkg::OPC_BITRS: begin
				wOp = bit_manip_pkg::OP_BITRS;
				wCycles = bit_manip_pkg::CYC_2BYTE;
			end
			bit_manip_pkg::OPC_AND: begin
				wOp = bit_manip_pkg::OP_AND;
				wCycles = bit_manip_pkg::CYC_2BYTE;
			end
			default: begin
				wOp = bit_manip_pkg::OP_NONE;
				wCycles = bit_manip_pkg::CYC_2BYTE;
			end
		endcase
	end

	// -----------------------------------------------------------------------
	// Operand selection and result.
	// -----------------------------------------------------------------------
	logic [7:0] workAddr;
	logic [7:0] workAddr2;
	logic [7:0] dstAddr;
	logic [7:0] srcAddr;
	logic [7:0] dstVal;
	logic [7:0] srcVal;
	logic [2:0] dstBit;
	logic [2:0] srcBit;
	logic resBit;
	logic [7:0] newDst;
	logic doWrite;
	logic doFlags;
	logic [7:0] newFlags;
	logic execNow;

	// The flags register shadows its slot in the register space.
	function automatic logic [7:0] rdReg(input logic [7:0] a,
		input logic [7:0] f, input logic [7:0] m);
		rdReg = (a == bit_manip_pkg::IDX_FLAGS[7:0]) ? f : m;
	endfunction : rdReg

	assign execNow = (stateR == bit_manip_pkg::ST_EXEC) && (cntR == 4'h1);
	assign workAddr = bit_manip_pkg::WORK_BASE | {4'h0, nibR};
	// Byte AND takes its source working register from the third byte.
	assign workAddr2 = bit_manip_pkg::WORK_BASE | {4'h0, thirdR[3:0]};

	// Selector bit chooses which side carries the indexed bit.
	always_comb begin
		dstAddr = workAddr;
		srcAddr = thirdR;
		dstBit = 3'h0;
		srcBit = single_bit_clear_op;
		if (opR == bit_manip_pkg::OP_AND) begin
			srcAddr = workAddr2;
		end else if ((opR == bit_manip_pkg::OP_BAND ||
			opR == bit_manip_pkg::OP_BIT_OR) && selR) begin
			dstAddr = thirdR;
			srcAddr = workAddr;
			dstBit = single_bit_clear_op;
			srcBit = 3'h0;
		end else if (opR == bit_manip_pkg::OP_TOGGLE ||
			opR == bit_manip_pkg::OP_BITRS) begin
			dstBit = single_bit_clear_op;
		end
	end

	assign dstVal = rdReg(dstAddr, flagsR, regs[dstAddr]);
	assign srcVal = rdReg(srcAddr, flagsR, regs[srcAddr]);

	// One result bit is merged back, every other destination bit kept; byte AND writes the whole byte.
	always_comb begin
		resBit = 1'b0;
		newDst = dstVal;
		doWrite = 1'b0;
		doFlags = 1'b0;
		newFlags = flagsR;
		case (opR)
			bit_manip_pkg::OP_BAND: begin
				resBit = dstVal[dstBit] & srcVal[srcBit];
				doWrite = 1'b1;
				doFlags = 1'b1;
			end
			bit_manip_pkg::OP_BIT_OR: begin
				resBit = dstVal[dstBit] | srcVal[srcBit];
				doWrite = 1'b1;
				doFlags = 1'b1;
			end
			bit_manip_pkg::OP_TOGGLE: begin
				resBit = ~dstVal[dstBit];
				doWrite = 1'b1;
				doFlags = 1'b1;
			end
			bit_manip_pkg::OP_BITRS: begin
				resBit = selR;
				doWrite = 1'b1;
			end
			bit_manip_pkg::OP_BIT_CMP: begin
				// Nothing is written back; only Z reports the match.
				newFlags[bit_manip_pkg::FLAG_Z] =
					(dstVal[0] == srcVal[srcBit]);
				doFlags = 1'b1;
			end
			bit_manip_pkg::OP_AND: begin
				doWrite = 1'b1;
				doFlags = 1'b1;
			end
			default: begin
				resBit = 1'b0;
			end
		endcase
		if (opR == bit_manip_pkg::OP_AND) begin
			newDst = dstVal & srcVal;
			newFlags[bit_manip_pkg::FLAG_Z] = (newDst == 8'h00);
			newFlags[bit_manip_pkg::FLAG_S] = newDst[7];
			newFlags[bit_manip_pkg::FLAG_V] = 1'b0;
		end else if (opR != bit_manip_pkg::OP_BIT_CMP) begin
			newDst[dstBit] = resBit;
			newFlags[bit_manip_pkg::FLAG_Z] = ~resBit;
			newFlags[bit_manip_pkg::FLAG_S] = 1'b0;
		end
	end

	// -----------------------------------------------------------------------
	// Sequencing.
	// -----------------------------------------------------------------------
	// The count stands for the instruction's cycle budget; the result lands
	// on its last cycle so software sees the documented latency.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			stateR <= bit_manip_pkg::ST_IDLE;
			cntR <= 4'h0;
		end else begin
			case (stateR)
				bit_manip_pkg::ST_IDLE: begin
					if (instrWr && wOp != bit_manip_pkg::OP_NONE) begin
						stateR <= bit_manip_pkg::ST_EXEC;
						cntR <= wCycles;
					end
				end
				bit_manip_pkg::ST_EXEC: begin
					cntR <= cntR - 4'h1;
					if (execNow) begin
						stateR <= bit_manip_pkg::ST_IDLE;
					end
				end
				default: begin
					stateR <= bit_manip_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Instruction fields are latched when the instruction is accepted.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			opR <= bit_manip_pkg::OP_NONE;
			nibR <= 4'h0;
			single_bit_clear_op <= 3'h0;
			selR <= 1'b0;
			thirdR <= 8'h00;
			illegalR <= 1'b0;
		end else if (instrWr) begin
			opR <= wOp;
			nibR <= dat_i[15:12];
			single_bit_clear_op <= dat_i[11:9];
			selR <= dat_i[8];
			thirdR <= dat_i[23:16];
			illegalR <= (wOp == bit_manip_pkg::OP_NONE);
		end
	end

	// -----------------------------------------------------------------------
	// Register file and flags.
	// -----------------------------------------------------------------------
	// Execution wins over a bus write to the same cycle; software should
	// not write registers while busy reads one.
	always_ff @(posedge clk_sys) begin
		if (execNow && doWrite &&
			dstAddr != bit_manip_pkg::IDX_FLAGS[7:0]) begin
			regs[dstAddr] <= newDst;
		end else if (wrReq && idx <= bit_manip_pkg::IDX_LAST_REG &&
			idx != bit_manip_pkg::IDX_FLAGS) begin
			regs[idx[7:0]] <= dat_i[7:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			flagsR <= bit_manip_pkg::FLAGS_RESET;
		end else if (execNow && doFlags) begin
			flagsR <= newFlags;
		end else if (execNow && doWrite &&
			dstAddr == bit_manip_pkg::IDX_FLAGS[7:0]) begin
			flagsR <= newDst;
		end else if (wrReq && idx == bit_manip_pkg::IDX_FLAGS) begin
			flagsR <= dat_i[7:0];
		end
	end

	// -----------------------------------------------------------------------
	// Bus answer.
	// -----------------------------------------------------------------------
	// Unmapped indexes answer with zero and ignore writes, so no cycle hangs.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ackR <= 1'b0;
			datR <= 32'h0000_0000;
		end else begin
			ackR <= req;
			datR <= 32'h0000_0000;
			if (req && !adr_i[11]) begin
				if (idx <= bit_manip_pkg::IDX_LAST_REG) begin
					datR[7:0] <= rdReg(idx[7:0], flagsR, regs[idx[7:0]]);
				end else if (idx == bit_manip_pkg::IDX_STATUS) begin
					datR[bit_manip_pkg::STAT_BUSY] <=
						(stateR == bit_manip_pkg::ST_EXEC);
					datR[bit_manip_pkg::STAT_ILLEGAL] <= illegalR;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			doneR <= 1'b0;
		end else begin
			doneR <= execNow; // Pulse in the cycle after the result lands.
		end
	end

	assign ack_o = ackR;
	assign dat_o = datR;
	assign done = doneR;
	assign busy = (stateR == bit_manip_pkg::ST_EXEC);

endmodule : bit_manipulation_unit

`default_nettype wire

// file: bit_manipulation_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bit_manipulation_unit_tb;
	logic clk_sys, srst, cycI, stbI, weI, ackO, busyO, doneO;
	logic [11:0] adrI;
	logic [3:0] selI;
	logic [31:0] datI, datO;
	logic [63:0] notes[$];
	logic [63:0] note;
	logic [7:0] sh[16];
	logic [7:0] fl;
	logic [7:0] ops[6] = '{8'h67, 8'h07, 8'h17, 8'h57, 8'h77, 8'h52};
	int mismatches, check_count;

	bit_manipulation_unit i_dut (.clk_sys(clk_sys), .srst(srst), .cyc_i(cycI),
		.stb_i(stbI), .we_i(weI), .adr_i(adrI), .sel_i(selI), .dat_i(datI),
		.dat_o(datO), .ack_o(ackO), .busy(busyO), .done(doneO));

	// Free-running system clock.
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic final_report;
		if (mismatches == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Each ack retires the oldest note; a zero mask marks a write.
	always @(posedge clk_sys) begin
		if (ackO === 1'b1) begin
			note = notes.pop_front();
			if (note[63:32] != 32'h0) begin
				chk(datO & note[63:32], note[31:0] & note[63:32]);
			end
		end
	end

	// One classic cycle, held until ack and then idle for a cycle.
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [63:0] n);
		int k;
		notes.push_back(n);
		cycI <= 1'b1;
		stbI <= 1'b1;
		weI <= w;
		adrI <= a;
		datI <= d;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (ackO !== 1'b1 && k < 20);
		if (ackO !== 1'b1) begin
			mismatches++;
			final_report;
		end
		cycI <= 1'b0;
		stbI <= 1'b0;
		@(posedge clk_sys);
	endtask : bus

	// Issue one instruction, track it in the shadow copy, then read all back.
	task automatic run(input logic [7:0] op, input logic [7:0] ob,
		input logic [3:0] t);
		logic [3:0] d;
		logic [2:0] b;
		logic x, y, r;
		int n;
		if (op == 8'h57) ob[0] = 1'b0;
		d = ob[7:4];
		b = ob[3:1];
		bus(1'b1, 12'h400, {8'h00, 4'hC, t, ob, op}, 64'h0);
		chk({31'h0, busyO}, 32'h1);
		x = ob[0] ? sh[t][b] : sh[d][0];
		y = ob[0] ? sh[d][0] : sh[t][b];
		r = (op == 8'h67) ? x & y : x | y;
		case (op)
			8'h67, 8'h07: begin
				if (ob[0]) sh[t][b] = r;
				else sh[d][0] = r;
				fl[bit_manip_pkg::FLAG_Z] = ~r;
			end
			8'h17: fl[bit_manip_pkg::FLAG_Z] = sh[d][0] == sh[t][b];
			8'h57: begin
				sh[d][b] = ~sh[d][b];
				fl[bit_manip_pkg::FLAG_Z] = ~sh[d][b];
			end
			8'h77: sh[d][b] = ob[0];
			default: begin
				sh[d] = sh[d] & sh[t];
				fl[bit_manip_pkg::FLAG_Z] = sh[d] == 8'h00;
				fl[bit_manip_pkg::FLAG_V] = 1'b0;
			end
		endcase
		if (op inside {8'h67, 8'h07, 8'h57}) fl[bit_manip_pkg::FLAG_S] = 1'b0;
		if (op == 8'h52) fl[bit_manip_pkg::FLAG_S] = sh[d][7];
		n = 0;
		while (doneO !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			n++;
		end
		chk(32'(n), (op inside {8'h57, 8'h77, 8'h52}) ? 32'h3 : 32'h5);
		if (doneO !== 1'b1) final_report;
		chk({31'h0, busyO}, 32'h0);
		for (int k = 0; k < 16; k++) begin
			bus(1'b0, 12'h300 + 12'(k * 4), 32'h0,
				{32'hFFFF_FFFF, 24'h0, sh[k]});
		end
		bus(1'b0, 12'h354, 32'h0, {24'hFF_FFFF, (op == 8'h52) ? 8'hFF :
			~(8'h01 << bit_manip_pkg::FLAG_V), 24'h0, fl});
	endtask : run

	// Reset, seed the registers, probe refusals, then random instructions.
	initial begin
		srst = 1'b1;
		cycI = 1'b0;
		stbI = 1'b0;
		weI = 1'b0;
		adrI = 12'h000;
		selI = 4'h1;
		datI = 32'h0;
		mismatches = 0;
		check_count = 0;
		void'($urandom(60));
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		bus(1'b0, 12'h354, 32'h0,
			{32'hFFFF_FFFF, 24'h0, bit_manip_pkg::FLAGS_RESET});
		fl = 8'($urandom);
		bus(1'b1, 12'h354, {24'h0, fl}, 64'h0);
		for (int k = 0; k < 16; k++) begin
			sh[k] = 8'($urandom);
			bus(1'b1, 12'h300 + 12'(k * 4), {24'h0, sh[k]}, 64'h0);
		end
		selI <= 4'h2;
		bus(1'b1, 12'h300, {24'h0, ~sh[0]}, 64'h0);
		selI <= 4'h1;
		bus(1'b0, 12'h800, 32'h0, {32'hFFFF_FFFF, 32'h0});
		bus(1'b1, 12'h400, 32'h0000_00FF, 64'h0);
		bus(1'b0, 12'h404, 32'h0, {32'hFFFF_FFFF, 32'h2});
		for (int i = 0; i < 36; i++) begin
			run(ops[i % 6], {7'($urandom), 1'(i / 6)}, 4'($urandom));
		end
		bus(1'b0, 12'h404, 32'h0, {32'hFFFF_FFFF, 32'h0});
		final_report;
	end
endmodule : bit_manipulation_unit_tb
`default_nettype wire
